// *** shared/epv_pkg.sv ***
package epv_pkg;
  // -----------------------------------------------------------------
  // vector map
  // -----------------------------------------------------------------
  localparam logic [15:0] VEC_RESET     = 16'hFFFE;
  localparam logic [15:0] VEC_CLK_MON   = 16'hFFFC;
  localparam logic [15:0] VEC_WATCHDOG  = 16'hFFFA;
  localparam logic [15:0] VEC_TRAP      = 16'hFFF8;
  localparam logic [15:0] VEC_SOFT_TRAP = 16'hFFF6;
  localparam logic [15:0] VEC_NMI_PIN   = 16'hFFF4;
  localparam logic [7:0]  VEC_PAGE      = 8'hFF;
  localparam logic [8:0]  VEC_TOP_BITS  = 9'h1FF;
  localparam logic [7:0]  MASK_LOW_BASE = 8'h80;
  localparam logic [7:0]  MASK_LOW_TOP  = 8'hF2;
  localparam int          MASK_SLOTS    = 58;
  localparam logic [5:0]  SLOT_PIN_IRQ  = 6'h39;
  localparam logic [7:0]  CODE_PIN_IRQ  = 8'hF2;
  localparam logic [7:0]  CODE_TICK     = 8'hF0;
  localparam logic [7:0]  CODE_SPI      = 8'hD8;
  localparam logic [7:0]  CODE_PA_EDGE  = 8'hDA;
  localparam logic [7:0]  CODE_PB_OVF   = 8'hCA;
  localparam logic [7:0]  CODE_DOWN_CNT = 8'hCC;

  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam logic [7:0]  OFS_FLAGS     = 8'h00;
  localparam logic [7:0]  OFS_ELEVATE   = 8'h04;
  localparam logic [7:0]  OFS_PIN_CTRL  = 8'h08;
  localparam logic [7:0]  OFS_WATCHDOG  = 8'h0C;
  localparam logic [7:0]  OFS_STATUS    = 8'h10;
  localparam int          POS_X_MASK    = 6;
  localparam int          POS_I_MASK    = 4;
  localparam int          POS_EDGE_SEL  = 7;
  localparam int          POS_CONNECT   = 6;
  localparam int          POS_CLK_MON   = 7;
  localparam int          POS_FORCE_MON = 6;
  localparam logic [7:0]  RST_FLAGS     = 8'h50;
  localparam logic [7:0]  RST_ELEVATE   = 8'hF2;
  localparam logic [7:0]  RST_PIN_CTRL  = 8'h40;
  localparam logic [7:0]  RST_WATCHDOG  = 8'h00;

  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic clk_mon_fail;
    logic watchdog_fail;
    logic illegal_op;
    logic soft_trap;
  } epv_nmi_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } epv_vector_t;
endpackage

// *** hdl/epv_sync3.sv ***
`timescale 1ns/100ps
// three-stage pin synchroniser; output moves only once stages two and three agree
module epv_sync3 #(
  parameter int           WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '1
) (
  input  wire logic             SYS_CLK,
  input  wire logic             RST_B,
  input  wire logic             CE,
  input  wire logic [WIDTH-1:0] PIN_IN,
  output logic      [WIDTH-1:0] PIN_OUT
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] agree;

  assign agree = ~(stage2_reg ^ stage3_reg);

  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      stage1_reg <= INIT;
      stage2_reg <= INIT;
      stage3_reg <= INIT;
      PIN_OUT    <= INIT;
    end
    else if (CE)
    begin
      stage1_reg <= PIN_IN;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      PIN_OUT    <= (agree & stage3_reg) | (~agree & PIN_OUT);
    end
  end
endmodule

// *** hdl/epv_exception_vectoring.sv ***
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
module epv_exception_vectoring
  import epv_pkg::*;
(
  input  wire logic                  SYS_CLK,
  input  wire logic                  RST_B,
  input  wire logic                  CE,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [7:0]            PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire epv_nmi_req_t          NMI_REQ,
  input  wire logic                  NMI_PIN_B,
  input  wire logic                  IRQ_PIN_B,
  input  wire logic [MASK_SLOTS-1:0] MASK_REQ,
  input  wire logic [MASK_SLOTS-1:0] MASK_EN,
  input  wire logic                  SERVICE_REQ,
  output epv_vector_t                VECTOR_OUT,
  output logic                       EXC_PENDING,
  output logic                       CCR_I_MASK,
  output logic                       CCR_X_MASK
);
  // -----------------------------------------------------------------
  // register state
  // -----------------------------------------------------------------
  logic [7:0]  flags_reg;
  logic [7:0]  elevate_reg;
  logic [7:0]  pin_ctrl_reg;
  logic [7:0]  watchdog_reg;
  logic        reset_pend_reg;
  logic        irq_latch_reg;
  logic        irq_prev_reg;
  logic        nmi_pin_b_s;
  logic        irq_pin_b_s;

  // pins arrive asynchronously; idle high so reset reads inactive
  epv_sync3 #(
    .WIDTH (2),
    .INIT  (2'h3)
  ) u_pin_sync (
    .SYS_CLK (SYS_CLK),
    .RST_B   (RST_B),
    .CE      (CE),
    .PIN_IN  ({NMI_PIN_B, IRQ_PIN_B}),
    .PIN_OUT ({nmi_pin_b_s, irq_pin_b_s})
  );

  // -----------------------------------------------------------------
  // apb decode
  // -----------------------------------------------------------------
  wire        apb_access = PSEL & PENABLE & ~PREADY;
  wire        apb_commit = PSEL & PENABLE & PREADY & CE;
  wire        apb_write  = apb_commit & PWRITE;
  wire        hit_flags  = (PADDR == OFS_FLAGS);
  wire        hit_elev   = (PADDR == OFS_ELEVATE);
  wire        hit_pin    = (PADDR == OFS_PIN_CTRL);
  wire        hit_wdog   = (PADDR == OFS_WATCHDOG);
  wire        hit_stat   = (PADDR == OFS_STATUS);
  wire        hit_any    = hit_flags | hit_elev | hit_pin | hit_wdog | hit_stat;
  wire        i_mask     = flags_reg[POS_I_MASK];
  wire        x_mask     = flags_reg[POS_X_MASK];
  wire        edge_sel   = pin_ctrl_reg[POS_EDGE_SEL];
  wire        connect    = pin_ctrl_reg[POS_CONNECT];
  wire [7:0]  status_val = {5'h00, reset_pend_reg, irq_latch_reg, EXC_PENDING};
  wire [7:0]  rd_byte    = hit_flags ? flags_reg    :
                           hit_elev  ? elevate_reg  :
                           hit_pin   ? pin_ctrl_reg :
                           hit_wdog  ? watchdog_reg :
                           hit_stat  ? status_val   : 8'h00;
  wire        elev_write = apb_write & hit_elev & i_mask;

  // -----------------------------------------------------------------
  // external pin request
  // -----------------------------------------------------------------
  wire        irq_fall   = irq_prev_reg & ~irq_pin_b_s;
  wire        irq_active = connect & (edge_sel ? irq_latch_reg : ~irq_pin_b_s);

  // -----------------------------------------------------------------
  // maskable arbitration
  // -----------------------------------------------------------------
  logic [MASK_SLOTS-1:0] mask_raw;
  logic [MASK_SLOTS-1:0] mask_live;
  logic [5:0]            best_slot;
  logic                  best_found;

  always_comb
  begin
    mask_raw               = MASK_REQ & MASK_EN;
    mask_raw[SLOT_PIN_IRQ] = irq_active;
    mask_live              = mask_raw & {MASK_SLOTS{~i_mask}};
  end

  // higher slot means higher vector, so the last hit in the loop wins
  always_comb
  begin
    best_slot  = 6'h00;
    best_found = 1'b0;
    for (int k = 0; k < MASK_SLOTS; k++)
    begin
      if (mask_live[k])
      begin
        best_slot  = 6'(k);
        best_found = 1'b1;
      end
    end
  end

  // an odd or out-of-range code simply elevates nothing
  wire [7:0]  elev_ofs   = 8'(elevate_reg - MASK_LOW_BASE);
  wire        elev_legal = (elevate_reg >= MASK_LOW_BASE) && (elevate_reg <= MASK_LOW_TOP)
                           && !elevate_reg[0];
  wire [5:0]  elev_slot  = elev_ofs[6:1];
  wire        elev_hit   = elev_legal && mask_live[elev_slot];
  wire [5:0]  win_slot   = elev_hit ? elev_slot : best_slot;
  // the vector comes from the slot, never from the elevation code itself
  wire [7:0]  win_low    = 8'(MASK_LOW_BASE + {1'b0, win_slot, 1'b0});

  // -----------------------------------------------------------------
  // non-maskable arbitration
  // -----------------------------------------------------------------
  wire        clk_mon_on = watchdog_reg[POS_CLK_MON] | watchdog_reg[POS_FORCE_MON];
  wire        nmi_clk    = NMI_REQ.clk_mon_fail & clk_mon_on;
  wire        nmi_pin    = ~nmi_pin_b_s & ~x_mask;
  wire        any_nmi    = nmi_clk | NMI_REQ.watchdog_fail | NMI_REQ.illegal_op
                           | NMI_REQ.soft_trap | nmi_pin;
  wire        any_active = reset_pend_reg | any_nmi | best_found;

  wire [15:0] win_vector = reset_pend_reg        ? VEC_RESET     :
                           nmi_clk               ? VEC_CLK_MON   :
                           NMI_REQ.watchdog_fail ? VEC_WATCHDOG  :
                           NMI_REQ.illegal_op    ? VEC_TRAP      :
                           NMI_REQ.soft_trap     ? VEC_SOFT_TRAP :
                           nmi_pin               ? VEC_NMI_PIN   :
                           best_found            ? {VEC_PAGE, win_low} :
                           VEC_TRAP;

  wire        take       = SERVICE_REQ & CE;
  wire        irq_served = take && (win_vector == {VEC_PAGE, CODE_PIN_IRQ});

  // -----------------------------------------------------------------
  // next-state values
  // -----------------------------------------------------------------
  wire [7:0]  flags_next    = (apb_write & hit_flags) ? PWDATA[7:0] : flags_reg;
  wire [7:0]  elevate_next  = elev_write ? PWDATA[7:0] : elevate_reg;
  wire [7:0]  pin_ctrl_next = (apb_write & hit_pin) ? PWDATA[7:0] : pin_ctrl_reg;
  wire [7:0]  watchdog_next = (apb_write & hit_wdog) ? PWDATA[7:0] : watchdog_reg;
  // a new edge in the serving cycle survives the clear
  wire        irq_latch_next = (edge_sel & irq_fall) | (irq_latch_reg & ~irq_served);
  wire        reset_pend_next = reset_pend_reg & ~(take & reset_pend_reg);

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      flags_reg      <= RST_FLAGS;
      elevate_reg    <= RST_ELEVATE;
      pin_ctrl_reg   <= RST_PIN_CTRL;
      watchdog_reg   <= RST_WATCHDOG;
      reset_pend_reg <= 1'b1;
      irq_latch_reg  <= 1'b0;
      irq_prev_reg   <= 1'b1;
    end
    else if (CE)
    begin
      flags_reg      <= flags_next;
      elevate_reg    <= elevate_next;
      pin_ctrl_reg   <= pin_ctrl_next;
      watchdog_reg   <= watchdog_next;
      reset_pend_reg <= reset_pend_next;
      irq_latch_reg  <= irq_latch_next;
      irq_prev_reg   <= irq_pin_b_s;
    end
  end

  // one wait state keeps every apb answer coming from a flop
  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else if (CE)
    begin
      PREADY  <= apb_access;
      PRDATA  <= apb_access ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      PSLVERR <= apb_access & ~hit_any;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      VECTOR_OUT  <= '{valid: 1'b0, addr: VEC_RESET};
      EXC_PENDING <= 1'b1;
      CCR_I_MASK  <= 1'b1;
      CCR_X_MASK  <= 1'b1;
    end
    else if (CE)
    begin
      VECTOR_OUT.valid <= take;
      VECTOR_OUT.addr  <= take ? win_vector : VECTOR_OUT.addr;
      EXC_PENDING      <= any_active;
      CCR_I_MASK       <= flags_next[POS_I_MASK];
      CCR_X_MASK       <= flags_next[POS_X_MASK];
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  sequence s_entry;
    take;
  endsequence

  sequence s_strobe(logic [15:0] v);
    VECTOR_OUT.valid && VECTOR_OUT.addr == v;
  endsequence

  vector_window_a: assert property (VECTOR_OUT.valid |-> VECTOR_OUT.addr[15:7] == VEC_TOP_BITS)
    else $error("vector outside top 128 bytes");
  entry_strobe_a: assert property (s_entry |=> VECTOR_OUT.valid)
    else $error("no vector strobe after entry");
  reset_first_a: assert property (s_entry ##0 reset_pend_reg |=> s_strobe(VEC_RESET))
    else $error("reset vector not taken first");
  clk_mon_order_a: assert property (s_entry ##0 !reset_pend_reg && nmi_clk
                                    |=> s_strobe(VEC_CLK_MON))
    else $error("clock monitor order wrong");
  pin_mask_a: assert property (s_strobe(VEC_NMI_PIN) |-> !$past(x_mask))
    else $error("masked pin request taken");
  global_mask_a: assert property (VECTOR_OUT.valid && VECTOR_OUT.addr < VEC_NMI_PIN
                                  |-> !$past(i_mask))
    else $error("maskable taken while masked");
  elev_lock_a: assert property (apb_write && hit_elev && !i_mask |=> $stable(elevate_reg))
    else $error("elevation written while unmasked");
  elev_win_a: assert property (s_entry ##0 elev_hit && !any_nmi && !reset_pend_reg
                               |=> s_strobe({VEC_PAGE, $past(elevate_reg)}))
    else $error("elevated source not first");
  empty_trap_a: assert property (s_entry ##0 !any_active |=> s_strobe(VEC_TRAP))
    else $error("empty entry missed trap");
  apb_answer_a: assert property (apb_access && CE |=> PREADY ##1 !PREADY)
    else $error("apb answer timing wrong");
endmodule

// *** verification/epv_core_model.sv ***
`timescale 1ns/100ps
// core side: asks for a vector after a chosen stall, then waits a bounded time for it
module epv_core_model
  import epv_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST_B,
  input  wire logic        fetch,
  input  wire logic [3:0]  slow,
  input  wire epv_vector_t vec,
  output logic             service_req,
  output logic             busy
);
  logic [4:0] cnt_reg;
  logic       sent_reg;

  always_ff @(posedge SYS_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      service_req <= 1'b0;
      busy        <= 1'b0;
      sent_reg    <= 1'b0;
      cnt_reg     <= 5'h00;
    end
    else if (fetch && !busy)
    begin
      busy     <= 1'b1;
      sent_reg <= 1'b0;
      cnt_reg  <= {1'b0, slow};
    end
    else if (busy)
    begin
      service_req <= 1'b0;
      if (!sent_reg && cnt_reg == 5'h00)
      begin
        service_req <= 1'b1;
        sent_reg    <= 1'b1;
        cnt_reg     <= 5'h10;
      end
      else if (cnt_reg != 5'h00)
        cnt_reg <= cnt_reg - 5'h01;
      // give up quietly; the bench sees the vector note left unmatched
      if (sent_reg && (vec.valid || cnt_reg == 5'h00))
        busy <= 1'b0;
    end
  end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
module tb_top
  import epv_pkg::*;
();
  logic              SYS_CLK, RST_B, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]        PADDR;
  logic [31:0]       PWDATA, PRDATA;
  epv_nmi_req_t      NMI_REQ;
  logic              NMI_PIN_B, IRQ_PIN_B, service_req, busy, fetch;
  logic              ce, EXC_PENDING, CCR_I_MASK, CCR_X_MASK;
  logic [MASK_SLOTS-1:0] MASK_REQ, MASK_EN, r;
  epv_vector_t       VECTOR_OUT;
  logic [3:0]        slow;
  logic [33:0]       ae;
  logic [15:0]       ve;
  logic [33:0]       apb_q[$];
  logic [15:0]       vec_q[$];
  logic [15:0]       nv[5];
  logic [7:0]        codes[4];
  int                error_cnt, compares, i;

  epv_exception_vectoring u_dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .CE(ce), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .NMI_REQ(NMI_REQ), .NMI_PIN_B(NMI_PIN_B),
    .IRQ_PIN_B(IRQ_PIN_B), .MASK_REQ(MASK_REQ), .MASK_EN(MASK_EN),
    .SERVICE_REQ(service_req), .VECTOR_OUT(VECTOR_OUT), .EXC_PENDING(EXC_PENDING),
    .CCR_I_MASK(CCR_I_MASK), .CCR_X_MASK(CCR_X_MASK));

  epv_core_model u_core (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .fetch(fetch), .slow(slow),
    .vec(VECTOR_OUT), .service_req(service_req), .busy(busy));

  initial
  begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end

  // results are matched oldest-first against what the drivers noted
  always @(posedge SYS_CLK)
  begin
    if (PREADY === 1'b1)
    begin
      compares++;
      if (apb_q.size() == 0)
      begin
        error_cnt++;
        $display("wrong value apb note exp 1 seen 0");
      end
      else
      begin
        ae = apb_q.pop_front();
        if (PSLVERR !== ae[32] || (ae[33] && PRDATA !== {24'h0, ae[7:0]}))
        begin
          error_cnt++;
          $display("wrong value apb %h exp %h/%b seen %h/%b",
                   PADDR, ae[7:0], ae[32], PRDATA, PSLVERR);
        end
      end
    end
    if (VECTOR_OUT.valid === 1'b1)
    begin
      ve = (vec_q.size() != 0) ? vec_q.pop_front() : 16'h0;
      compares++;
      if (VECTOR_OUT.addr !== ve)
      begin
        error_cnt++;
        $display("wrong value vector exp %h seen %h", ve, VECTOR_OUT.addr);
      end
    end
  end

  task automatic stop_test();
    if (apb_q.size() + vec_q.size() != 0)
    begin
      error_cnt++;
      $display("wrong value notes left exp 0 seen %0d", apb_q.size() + vec_q.size());
    end
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic e, input logic s);
    compares++;
    if (s !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %b seen %b", nm, e, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, d, x, input logic er);
    int n;
    apb_q.push_back({~w, er, 24'h0, x});
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do
    begin
      @(posedge SYS_CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 20);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge SYS_CLK);
    if (n >= 20)
    begin
      error_cnt++;
      $display("wrong value apb wait exp 1 seen 0");
      stop_test();
    end
  endtask

  task automatic svc(input logic [15:0] x);
    int n;
    vec_q.push_back(x);
    slow <= 4'($urandom_range(3));
    fetch <= 1'b1;
    @(posedge SYS_CLK);
    fetch <= 1'b0;
    n = 0;
    do
    begin
      @(posedge SYS_CLK);
      n++;
    end
    while (busy !== 1'b0 && n < 40);
    if (n >= 40)
    begin
      error_cnt++;
      $display("wrong value service wait exp 0 seen 1");
      stop_test();
    end
  endtask

  // highest requesting slot wins unless an even in-range code elevates a requester
  function automatic logic [15:0] mvec(input logic [MASK_SLOTS-1:0] q, input logic [7:0] el);
    logic [5:0] es;
    es = 6'((el - 8'h80) >> 1);
    if (!el[0] && el >= MASK_LOW_BASE && el <= MASK_LOW_TOP && q[es])
      return {VEC_PAGE, el};
    for (int k = MASK_SLOTS - 1; k >= 0; k--)
      if (q[k])
        return 16'hFF80 + 16'(2 * k);
    return VEC_TRAP;
  endfunction

  function automatic logic [MASK_SLOTS-1:0] rnd();
    return {1'b0, 25'($urandom) & 25'($urandom), $urandom & $urandom};
  endfunction

  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  initial
  begin
    i = $urandom(32'h350D);
    nv = '{VEC_CLK_MON, VEC_WATCHDOG, VEC_TRAP, VEC_SOFT_TRAP, VEC_NMI_PIN};
    codes = '{CODE_PA_EDGE, CODE_PB_OVF, CODE_DOWN_CNT, CODE_SPI};
    {RST_B, PSEL, PENABLE, PWRITE, PADDR, PWDATA, fetch, slow} = '0;
    {NMI_REQ, MASK_REQ, error_cnt, compares} = '0;
    {NMI_PIN_B, IRQ_PIN_B, ce} = 3'b111;
    MASK_EN = '1;
    repeat (6) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    apb(1'b0, OFS_FLAGS, 8'h00, RST_FLAGS, 1'b0);
    apb(1'b0, OFS_ELEVATE, 8'h00, RST_ELEVATE, 1'b0);
    apb(1'b0, OFS_PIN_CTRL, 8'h00, RST_PIN_CTRL, 1'b0);
    apb(1'b0, OFS_WATCHDOG, 8'h00, RST_WATCHDOG, 1'b0);
    apb(1'b1, 8'h14, 8'hFF, 8'h00, 1'b1);
    chk("ccr_i_mask", 1'b1, CCR_I_MASK);
    chk("ccr_x_mask", 1'b1, CCR_X_MASK);
    chk("exc_pending", 1'b1, EXC_PENDING);
    svc(VEC_RESET);
    chk("exc_pending", 1'b0, EXC_PENDING);
    svc(VEC_TRAP);
    // clock enable low must hold every register, the pending flag included
    ce <= 1'b0;
    NMI_REQ <= 4'h1;
    repeat (4) @(posedge SYS_CLK);
    chk("frozen pending", 1'b0, EXC_PENDING);
    ce <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    chk("exc_pending", 1'b1, EXC_PENDING);
    apb(1'b1, OFS_WATCHDOG, 8'h40, 8'h00, 1'b0);
    apb(1'b1, OFS_FLAGS, 8'h10, 8'h00, 1'b0);
    chk("ccr_x_mask", 1'b0, CCR_X_MASK);
    chk("ccr_i_mask", 1'b1, CCR_I_MASK);
    NMI_PIN_B <= 1'b0;
    for (i = 0; i < 5; i++)
    begin
      NMI_REQ <= 4'(4'hF >> i);
      repeat (8) @(posedge SYS_CLK);
      svc(nv[i]);
    end
    NMI_REQ <= 4'h8;
    apb(1'b1, OFS_WATCHDOG, 8'h80, 8'h00, 1'b0);
    svc(VEC_CLK_MON);
    apb(1'b1, OFS_WATCHDOG, 8'h00, 8'h00, 1'b0);
    svc(VEC_NMI_PIN);
    apb(1'b1, OFS_FLAGS, 8'h50, 8'h00, 1'b0);
    svc(VEC_TRAP);
    NMI_REQ <= 4'h0;
    NMI_PIN_B <= 1'b1;
    apb(1'b1, OFS_ELEVATE, CODE_SPI, 8'h00, 1'b0);
    apb(1'b0, OFS_ELEVATE, 8'h00, CODE_SPI, 1'b0);
    r = rnd();
    r[44] = 1'b1;
    MASK_REQ <= r;
    svc(VEC_TRAP);
    apb(1'b1, OFS_FLAGS, 8'h40, 8'h00, 1'b0);
    chk("ccr_i_mask", 1'b0, CCR_I_MASK);
    svc(mvec(r, CODE_SPI));
    apb(1'b1, OFS_ELEVATE, CODE_DOWN_CNT, 8'h00, 1'b0);
    apb(1'b0, OFS_ELEVATE, 8'h00, CODE_SPI, 1'b0);
    MASK_EN[44] <= 1'b0;
    r[44] = 1'b0;
    svc(mvec(r, CODE_SPI));
    MASK_EN <= '1;
    for (i = 0; i < 8; i++)
    begin
      apb(1'b1, OFS_FLAGS, 8'h50, 8'h00, 1'b0);
      apb(1'b1, OFS_ELEVATE, codes[i % 4], 8'h00, 1'b0);
      apb(1'b1, OFS_FLAGS, 8'h40, 8'h00, 1'b0);
      r = rnd();
      MASK_REQ <= r;
      svc(mvec(r, codes[i % 4]));
    end
    apb(1'b1, OFS_FLAGS, 8'h50, 8'h00, 1'b0);
    apb(1'b1, OFS_ELEVATE, 8'h81, 8'h00, 1'b0);
    apb(1'b1, OFS_PIN_CTRL, 8'hC0, 8'h00, 1'b0);
    apb(1'b1, OFS_FLAGS, 8'h40, 8'h00, 1'b0);
    r = rnd();
    MASK_REQ <= r;
    IRQ_PIN_B <= 1'b0;
    repeat (6) @(posedge SYS_CLK);
    IRQ_PIN_B <= 1'b1;
    repeat (8) @(posedge SYS_CLK);
    apb(1'b0, OFS_STATUS, 8'h00, 8'h03, 1'b0);
    svc(16'hFFF2);
    svc(mvec(r, 8'h81));
    apb(1'b1, OFS_PIN_CTRL, 8'h40, 8'h00, 1'b0);
    IRQ_PIN_B <= 1'b0;
    repeat (8) @(posedge SYS_CLK);
    svc(16'hFFF2);
    svc(16'hFFF2);
    // a disconnected pin must not request even while it is held low
    apb(1'b1, OFS_PIN_CTRL, 8'h00, 8'h00, 1'b0);
    svc(mvec(r, 8'h81));
    stop_test();
  end
endmodule
